// ---- logic/ppgc_pattern_gen_check.sv ----
// pattern generator / checker for one link: register file on a classic
// wishbone slave, generator on one payload stream, checker on the other.
// assumes bit strobes, slot and bit position come from logic on sys_clk_in.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module ppgc_pattern_gen_check
(
   input  wire logic        sys_clk_in,        // 100 MHz system clock
   input  wire logic        rstn_in,           // async reset, active low
   // classic wishbone slave
   input  wire logic [11:0] wb_adr_in,         // byte address
   input  wire logic [31:0] wb_dat_in,         // write data
   input  wire logic [3:0]  wb_sel_in,         // byte lanes
   input  wire logic        wb_we_in,          // write
   input  wire logic        wb_cyc_in,         // cycle
   input  wire logic        wb_stb_in,         // strobe
   output logic      [31:0] wb_dat_out,        // read data
   output logic             wb_ack_out,        // acknowledge
   // transmit payload stream
   input  wire logic        tx_valid_in,       // one bit this cycle
   input  wire logic        tx_data_in,        // bit value
   input  wire logic [4:0]  tx_slot_in,        // channel / timeslot
   input  wire logic [2:0]  tx_bit_in,         // bit in slot, 0 = msb
   output logic             tx_valid_out,      // delayed strobe
   output logic             tx_data_out,       // bit, maybe replaced
   // receive payload stream
   input  wire logic        rx_valid_in,       // one bit this cycle
   input  wire logic        rx_data_in,        // bit value
   input  wire logic [4:0]  rx_slot_in,        // channel / timeslot
   input  wire logic [2:0]  rx_bit_in,         // bit in slot, 0 = msb
   output logic             rx_valid_out,      // delayed strobe
   output logic             rx_data_out,       // bit, maybe replaced
   // monitoring
   output logic             bit_error_out,     // one-cycle error event
   output logic             int_n_out          // interrupt, active low
);

   // control and status registers
   logic [7:0]  pat_ctrl_reg,  pat_ctrl_next;
   logic [7:0]  stat_ctrl_reg, stat_ctrl_next;
   logic [7:0]  test_conf_reg, test_conf_next;
   logic [31:0] chan_sel_reg,  chan_sel_next;
   logic        ber_flag_reg,  ber_flag_next;
   logic        syn_flag_reg,  syn_flag_next;
   logic [15:0] err_cnt_reg,   err_cnt_next;
   logic        ins_pend_reg,  ins_pend_next;
   logic        wb_ack_reg,    wb_ack_next;
   logic [31:0] wb_dat_reg,    wb_dat_next;
   logic        int_n_reg,     int_n_next;
   // generator and checker state
   logic        en_prev_reg,   en_prev_next;
   logic [19:0] gen_lfsr_reg,  gen_lfsr_next;
   logic [19:0] chk_lfsr_reg,  chk_lfsr_next;
   logic [4:0]  match_reg,     match_next;
   logic [5:0]  win_reg,       win_next;
   logic [3:0]  win_err_reg,   win_err_next;
   logic        sync_reg,      sync_next;
   logic        err_evt_reg,   err_evt_next;
   logic        tx_v_reg,      tx_v_next;
   logic        tx_d_reg,      tx_d_next;
   logic        rx_v_reg,      rx_v_next;
   logic        rx_d_reg,      rx_d_next;

   // decoded controls
   logic        test_en;
   logic        gen_dir;
   logic [1:0]  frame_mode;
   logic [1:0]  seq_sel;
   logic        en_rise;
   logic        bus_req;
   logic        bus_wr;
   logic [9:0]  reg_idx;
   // stream routing
   logic        g_valid, g_data, g_take;
   logic [4:0]  g_slot;
   logic [2:0]  g_bit;
   logic        c_valid, c_data, c_take;
   logic [4:0]  c_slot;
   logic [2:0]  c_bit;
   logic        gen_bit, gen_out;
   logic        chk_bit, chk_pred;
   logic        mismatch;

   // feedback of the selected maximal-length register, x^n + x^m + 1
   function automatic logic lfsr_fb(input logic [19:0] s, input logic [1:0] sel);
      logic fb;
      fb = 1'b0;
      unique case (sel)
         ppgc_pkg::SEQ_2E15: fb = s[14] ^ s[13];
         ppgc_pkg::SEQ_2E20: fb = s[19] ^ s[2];
         default:            fb = s[10] ^ s[8];
      endcase
      return fb;
   endfunction

   // is this bit of the stream under test in the current framing mode
   function automatic logic bit_taken(input logic [1:0] mode, input logic [31:0] chans,
                                      input logic [4:0] slot, input logic [2:0] bidx);
      logic t;
      t = 1'b0;
      unique case (mode)
         ppgc_pkg::PPGC_UNFRAMED: t = 1'b1;
         ppgc_pkg::PPGC_FRAMED8:  t = chans[slot];
         ppgc_pkg::PPGC_FRAMED7:  t = chans[slot] &&
                                      (bidx != ppgc_pkg::LSB_BIT_INDEX);
         default:                 t = 1'b0;                 // reserved: nothing touched
      endcase
      return t;
   endfunction

   // field decode
   assign test_en    = test_conf_reg[ppgc_pkg::TEST_EN_BIT];
   assign gen_dir    = test_conf_reg[ppgc_pkg::GEN_DIR_BIT];
   assign frame_mode = test_conf_reg[ppgc_pkg::FRAME_MODE_LSB +: 2];
   assign seq_sel    = pat_ctrl_reg[ppgc_pkg::SEQ_SEL_LSB +: 2];
   assign en_rise    = test_en && !en_prev_reg;
   assign bus_req    = wb_cyc_in && wb_stb_in && !wb_ack_reg;
   assign bus_wr     = bus_req && wb_we_in;
   assign reg_idx    = wb_adr_in[11:2];

   // generator on one stream, checker on the other
   always_comb
   begin
      if (!gen_dir)
      begin
         g_valid = tx_valid_in;
         g_data  = tx_data_in;
         g_slot  = tx_slot_in;
         g_bit   = tx_bit_in;
         c_valid = rx_valid_in;
         c_data  = rx_data_in;
         c_slot  = rx_slot_in;
         c_bit   = rx_bit_in;
      end
      else
      begin
         g_valid = rx_valid_in;
         g_data  = rx_data_in;
         g_slot  = rx_slot_in;
         g_bit   = rx_bit_in;
         c_valid = tx_valid_in;
         c_data  = tx_data_in;
         c_slot  = tx_slot_in;
         c_bit   = tx_bit_in;
      end
      g_take   = test_en && !en_rise && g_valid &&
                 bit_taken(frame_mode, chan_sel_reg, g_slot, g_bit);
      c_take   = test_en && !en_rise && c_valid &&
                 bit_taken(frame_mode, chan_sel_reg, c_slot, c_bit);
      gen_bit  = lfsr_fb(gen_lfsr_reg, seq_sel);
      // invert first, then the single flipped bit lands on top
      gen_out  = gen_bit ^ pat_ctrl_reg[ppgc_pkg::GEN_INV_BIT] ^ ins_pend_reg;
      chk_bit  = c_data ^ pat_ctrl_reg[ppgc_pkg::CHK_INV_BIT];
      chk_pred = lfsr_fb(chk_lfsr_reg, seq_sel);
      mismatch = c_take && (chk_bit != chk_pred);
   end

   // pattern datapath next state
   always_comb
   begin
      en_prev_next  = test_en;
      gen_lfsr_next = gen_lfsr_reg;
      chk_lfsr_next = chk_lfsr_reg;
      match_next    = match_reg;
      win_next      = win_reg;
      win_err_next  = win_err_reg;
      sync_next     = sync_reg;
      err_evt_next  = 1'b0;
      tx_v_next     = tx_valid_in;
      tx_d_next     = tx_data_in;
      rx_v_next     = rx_valid_in;
      rx_d_next     = rx_data_in;
      if (en_rise)
      begin
         // restart both ends from a known seed, checker back to hunting
         gen_lfsr_next = ppgc_pkg::LFSR_SEED;
         chk_lfsr_next = ppgc_pkg::LFSR_SEED;
         match_next    = 5'h00;
         win_next      = 6'h00;
         win_err_next  = 4'h0;
         sync_next     = 1'b0;
      end
      if (g_take)
      begin
         gen_lfsr_next = {gen_lfsr_reg[18:0], gen_bit};
         if (!gen_dir)
            tx_d_next = gen_out;
         else
            rx_d_next = gen_out;
      end
      if (c_take)
      begin
         if (!sync_reg)
         begin
            // hunting: load received bits so the register locks onto the stream
            chk_lfsr_next = {chk_lfsr_reg[18:0], chk_bit};
            if (chk_bit != chk_pred)
               match_next = 5'h00;
            else if (match_reg == ppgc_pkg::SYNC_MATCH_COUNT - 5'h01)
            begin
               match_next   = 5'h00;
               sync_next    = 1'b1;
               win_next     = 6'h00;
               win_err_next = 4'h0;
            end
            else
               match_next = match_reg + 5'h01;
         end
         else
         begin
            // locked: run free so a line error is not fed back
            chk_lfsr_next = {chk_lfsr_reg[18:0], chk_pred};
            err_evt_next  = mismatch;
            if (mismatch && win_err_reg == ppgc_pkg::WINDOW_ERR_LIMIT)
            begin
               sync_next    = 1'b0;
               win_next     = 6'h00;
               win_err_next = 4'h0;
            end
            else if (win_reg == ppgc_pkg::WINDOW_BITS - 6'h01)
            begin
               win_next     = 6'h00;
               win_err_next = 4'h0;
            end
            else
            begin
               win_next     = win_reg + 6'h01;
               win_err_next = win_err_reg + {3'h0, mismatch};
            end
         end
      end
   end

   // pattern datapath registers
   always_ff @(posedge sys_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         en_prev_reg  <= 1'b0;
         gen_lfsr_reg <= ppgc_pkg::LFSR_SEED;
         chk_lfsr_reg <= ppgc_pkg::LFSR_SEED;
         match_reg    <= 5'h00;
         win_reg      <= 6'h00;
         win_err_reg  <= 4'h0;
         sync_reg     <= 1'b0;
         err_evt_reg  <= 1'b0;
         tx_v_reg     <= 1'b0;
         tx_d_reg     <= 1'b0;
         rx_v_reg     <= 1'b0;
         rx_d_reg     <= 1'b0;
      end
      else
      begin
         en_prev_reg  <= en_prev_next;
         gen_lfsr_reg <= gen_lfsr_next;
         chk_lfsr_reg <= chk_lfsr_next;
         match_reg    <= match_next;
         win_reg      <= win_next;
         win_err_reg  <= win_err_next;
         sync_reg     <= sync_next;
         err_evt_reg  <= err_evt_next;
         tx_v_reg     <= tx_v_next;
         tx_d_reg     <= tx_d_next;
         rx_v_reg     <= rx_v_next;
         rx_d_reg     <= rx_d_next;
      end
   end

   // register file, flags and bus answer next state
   always_comb
   begin
      pat_ctrl_next  = pat_ctrl_reg;
      stat_ctrl_next = stat_ctrl_reg;
      test_conf_next = test_conf_reg;
      chan_sel_next  = chan_sel_reg;
      ber_flag_next  = ber_flag_reg;
      syn_flag_next  = syn_flag_reg;
      err_cnt_next   = err_cnt_reg;
      ins_pend_next  = ins_pend_reg;
      wb_ack_next    = bus_req;
      wb_dat_next    = 32'h0000_0000;
      // a pending flip is spent on the next generated bit
      if (g_take)
         ins_pend_next = 1'b0;
      if (bus_wr)
      begin
         unique case (reg_idx)
            ppgc_pkg::IDX_PATTERN_CONTROL:
               if (wb_sel_in[0])
                  pat_ctrl_next = {4'h0, wb_dat_in[3:0]};
            ppgc_pkg::IDX_STATUS_ERR_CTRL:
               if (wb_sel_in[0])
               begin
                  stat_ctrl_next = {4'h0, wb_dat_in[3:2], 2'b00};
                  if (wb_dat_in[ppgc_pkg::ERR_INSERT_BIT])
                     ins_pend_next = 1'b1;
               end
            ppgc_pkg::IDX_INTERRUPT_FLAGS:
               if (wb_sel_in[0])
               begin
                  // write one to clear
                  if (wb_dat_in[ppgc_pkg::BER_FLAG_BIT])
                     ber_flag_next = 1'b0;
                  if (wb_dat_in[ppgc_pkg::SYNC_FLAG_BIT])
                     syn_flag_next = 1'b0;
               end
            ppgc_pkg::IDX_ERROR_COUNT:
               err_cnt_next = 16'h0000;
            ppgc_pkg::IDX_PAYLOAD_TEST_CONF:
               if (wb_sel_in[0])
                  test_conf_next = {4'h0, wb_dat_in[3:0]};
            ppgc_pkg::IDX_CHANNEL_SELECT:
               for (int i = 0; i < 4; i++)
                  if (wb_sel_in[i])
                     chan_sel_next[i*8 +: 8] = wb_dat_in[i*8 +: 8];
            default: ;
         endcase
      end
      // hardware set wins over a clear in the same cycle
      if (err_evt_next)
      begin
         ber_flag_next = 1'b1;
         if (err_cnt_reg != 16'hFFFF)
            err_cnt_next = err_cnt_reg + 16'h0001;
      end
      if (sync_next != sync_reg)
         syn_flag_next = 1'b1;
      if (bus_req && !wb_we_in)
      begin
         unique case (reg_idx)
            ppgc_pkg::IDX_PATTERN_CONTROL:   wb_dat_next = {24'h000000, pat_ctrl_reg};
            ppgc_pkg::IDX_STATUS_ERR_CTRL:   wb_dat_next = {24'h000000, stat_ctrl_reg[7:2],
                                                            sync_reg, 1'b0};
            ppgc_pkg::IDX_INTERRUPT_FLAGS:   wb_dat_next = {30'h0, syn_flag_reg,
                                                            ber_flag_reg};
            ppgc_pkg::IDX_ERROR_COUNT:       wb_dat_next = {16'h0000, err_cnt_reg};
            ppgc_pkg::IDX_PAYLOAD_TEST_CONF: wb_dat_next = {24'h000000, test_conf_reg};
            ppgc_pkg::IDX_CHANNEL_SELECT:    wb_dat_next = chan_sel_reg;
            default:                         wb_dat_next = 32'h0000_0000;
         endcase
      end
      // any enabled pending flag pulls the line low
      int_n_next = !((ber_flag_next && stat_ctrl_next[ppgc_pkg::BER_IRQ_EN_BIT]) ||
                     (syn_flag_next && stat_ctrl_next[ppgc_pkg::SYNC_IRQ_EN_BIT]));
   end

   // register file registers
   always_ff @(posedge sys_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         pat_ctrl_reg  <= ppgc_pkg::PATTERN_CONTROL_RST;
         stat_ctrl_reg <= ppgc_pkg::STATUS_CTRL_RST;
         test_conf_reg <= ppgc_pkg::TEST_CONF_RST;
         chan_sel_reg  <= ppgc_pkg::CHANNEL_SELECT_RST;
         ber_flag_reg  <= 1'b0;
         syn_flag_reg  <= 1'b0;
         err_cnt_reg   <= 16'h0000;
         ins_pend_reg  <= 1'b0;
         wb_ack_reg    <= 1'b0;
         wb_dat_reg    <= 32'h0000_0000;
         int_n_reg     <= 1'b1;
      end
      else
      begin
         pat_ctrl_reg  <= pat_ctrl_next;
         stat_ctrl_reg <= stat_ctrl_next;
         test_conf_reg <= test_conf_next;
         chan_sel_reg  <= chan_sel_next;
         ber_flag_reg  <= ber_flag_next;
         syn_flag_reg  <= syn_flag_next;
         err_cnt_reg   <= err_cnt_next;
         ins_pend_reg  <= ins_pend_next;
         wb_ack_reg    <= wb_ack_next;
         wb_dat_reg    <= wb_dat_next;
         int_n_reg     <= int_n_next;
      end
   end

   // outputs straight from flops
   assign wb_ack_out    = wb_ack_reg;
   assign wb_dat_out    = wb_dat_reg;
   assign tx_valid_out  = tx_v_reg;
   assign tx_data_out   = tx_d_reg;
   assign rx_valid_out  = rx_v_reg;
   assign rx_data_out   = rx_d_reg;
   assign bit_error_out = err_evt_reg;
   assign int_n_out     = int_n_reg;

endmodule

// ---- logic/ppgc_pkg.sv ----
// package for the pattern generator / checker block: register map,
// field positions, reset values, modes and checker thresholds.
// assumes a 32-bit classic wishbone slave with byte addresses.
package ppgc_pkg;

   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_PATTERN_CONTROL   = 10'h071;
   localparam logic [9:0] IDX_STATUS_ERR_CTRL   = 10'h072;
   localparam logic [9:0] IDX_INTERRUPT_FLAGS   = 10'h073;
   localparam logic [9:0] IDX_ERROR_COUNT       = 10'h074;
   localparam logic [9:0] IDX_PAYLOAD_TEST_CONF = 10'h0C7;
   localparam logic [9:0] IDX_CHANNEL_SELECT    = 10'h0C8;

   // pattern_control fields
   localparam int SEQ_SEL_LSB      = 0;
   localparam int GEN_INV_BIT      = 2;
   localparam int CHK_INV_BIT      = 3;
   // pattern_status_error_control fields
   localparam int ERR_INSERT_BIT   = 0;
   localparam int SYNC_STATUS_BIT  = 1;
   localparam int BER_IRQ_EN_BIT   = 2;
   localparam int SYNC_IRQ_EN_BIT  = 3;
   // pattern_interrupt_flags fields
   localparam int BER_FLAG_BIT     = 0;
   localparam int SYNC_FLAG_BIT    = 1;
   // payload_test_configuration fields
   localparam int TEST_EN_BIT      = 0;
   localparam int FRAME_MODE_LSB   = 1;
   localparam int GEN_DIR_BIT      = 3;

   // reset values
   localparam logic [7:0]  PATTERN_CONTROL_RST = 8'h00;
   localparam logic [7:0]  STATUS_CTRL_RST     = 8'h00;
   localparam logic [7:0]  TEST_CONF_RST       = 8'h00;
   localparam logic [31:0] CHANNEL_SELECT_RST  = 32'h0000_0000;
   localparam logic [19:0] LFSR_SEED           = 20'hFFFFF;

   // framing modes
   typedef enum logic [1:0] {
      PPGC_UNFRAMED = 2'b00,
      PPGC_FRAMED8  = 2'b01,
      PPGC_FRAMED7  = 2'b10,
      PPGC_MODE_RSV = 2'b11
   } ppgc_frame_mode_t;

   // sequence choices
   localparam logic [1:0] SEQ_2E11 = 2'b00;
   localparam logic [1:0] SEQ_2E15 = 2'b01;
   localparam logic [1:0] SEQ_2E20 = 2'b10;

   // checker thresholds
   localparam logic [4:0] SYNC_MATCH_COUNT = 5'h18;   // consecutive matches to lock
   localparam logic [5:0] WINDOW_BITS      = 6'h30;   // 48-bit window
   localparam logic [3:0] WINDOW_ERR_LIMIT = 4'hA;    // more than this loses lock
   localparam logic [2:0] LSB_BIT_INDEX    = 3'h7;    // index 7 is the lsb of a slot

endpackage

// ---- tb/ppgc_link_model.sv ----
// far side of both payload paths: bit counter and a loop from tx to rx.
// assumes one payload bit per clock, transmit output fed back as loop_in.
`timescale 1ns/1ps
module ppgc_link_model
(
   input  wire logic       sys_clk_in,  // system clock
   input  wire logic       rstn_in,     // async reset, active low
   input  wire logic       loop_in,     // transmit bit coming back
   input  wire logic       flip_in,     // corrupt every looped bit
   output logic            tx_bit_out,  // transmit payload bit
   output logic            rx_bit_out,  // looped receive bit
   output logic [4:0]      slot_out,    // timeslot
   output logic [2:0]      pos_out      // bit in slot, msb first
);
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic       rx_reg;
   logic       rx_next;
   // next values: walk the frame, carry the bit back
   always_comb
   begin
      cnt_next = cnt_reg + 8'h01;
      rx_next  = loop_in ^ flip_in;
   end
   // the loop adds one cycle, as a real line would
   always_ff @(posedge sys_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         cnt_reg <= 8'h00;
         rx_reg  <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         rx_reg  <= rx_next;
      end
   end
   // irregular payload so a stuck output shows
   assign tx_bit_out = cnt_reg[2] ^ cnt_reg[5];
   assign rx_bit_out = rx_reg;
   assign slot_out   = cnt_reg[7:3];
   assign pos_out    = cnt_reg[2:0];
endmodule

// ---- tb/ppgc_pattern_assertions.sv ----
// checker on the top ports: bus timing, read data, streams, interrupt.
// assumes one clock domain and the active-low reset of the top module.
`timescale 1ns/1ps
module ppgc_checker
(
   input wire logic        sys_clk_in,    // system clock
   input wire logic        rstn_in,       // async reset, active low
   input wire logic [11:0] wb_adr_in,     // byte address
   input wire logic        wb_we_in,      // write
   input wire logic        wb_cyc_in,     // cycle
   input wire logic        wb_stb_in,     // strobe
   input wire logic [31:0] wb_dat_out,    // read data
   input wire logic        wb_ack_out,    // acknowledge
   input wire logic        tx_valid_in,   // tx strobe in
   input wire logic        rx_valid_in,   // rx strobe in
   input wire logic        tx_valid_out,  // tx strobe out
   input wire logic        rx_valid_out,  // rx strobe out
   input wire logic        bit_error_out, // error event
   input wire logic        int_n_out      // interrupt, active low
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   logic [9:0] idx;
   logic       small_reg;
   logic       unmapped;
   // register decode of the current request
   assign idx       = wb_adr_in[11:2];
   assign small_reg = idx inside {10'h071, 10'h072, 10'h073, 10'h0C7};
   assign unmapped  = !small_reg && !(idx inside {10'h074, 10'h0C8});
   sequence s_take;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   sequence s_answer;
      wb_ack_out ##1 !wb_ack_out;
   endsequence
   chk_ack_one_pulse: assert property (s_take |=> s_answer)
      else $error("ack not a single pulse one cycle after request");
   chk_ack_has_req: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
      else $error("ack without request");
   chk_dat_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
      else $error("read data not zero outside ack");
   chk_upper_bits_zero: assert property (wb_ack_out && !wb_we_in && small_reg
      |-> wb_dat_out[31:8] == 24'h0) else $error("upper read bits not zero");
   chk_unmapped_zero: assert property (wb_ack_out && !wb_we_in && unmapped
      |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
   chk_insert_reads_zero: assert property (wb_ack_out && !wb_we_in && idx == 10'h072
      |-> !wb_dat_out[0]) else $error("error insert bit reads one");
   chk_err_has_bit: assert property (bit_error_out |-> $past(rx_valid_in || tx_valid_in))
      else $error("error event without input bit");
   chk_valid_delay: assert property ($past(rstn_in) |-> {tx_valid_out, rx_valid_out} ==
      $past({tx_valid_in, rx_valid_in})) else $error("stream strobe not delayed one cycle");
   chk_int_reset_high: assert property ($rose(rstn_in) |-> int_n_out)
      else $error("interrupt low after reset");
endmodule
bind ppgc_pattern_gen_check ppgc_checker ppgc_checker_i
(
   .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .wb_adr_in(wb_adr_in),
   .wb_we_in(wb_we_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .tx_valid_in(tx_valid_in),
   .rx_valid_in(rx_valid_in), .tx_valid_out(tx_valid_out), .rx_valid_out(rx_valid_out),
   .bit_error_out(bit_error_out), .int_n_out(int_n_out)
);

// ---- tb/tb.sv ----
// testbench: bus tasks, looped payload, one task per scenario.
// assumes the link model loops transmit output back into receive.
`timescale 1ns/1ps
module tb;
   logic        sys_clk_in = 1'b0;
   logic        rstn_in    = 1'b0;
   logic [11:0] wb_adr_in  = 12'h000;
   logic [31:0] wb_dat_in  = 32'h0;
   logic        wb_we_in   = 1'b0;
   logic        wb_cyc_in  = 1'b0;
   logic        wb_stb_in  = 1'b0;
   logic        flip       = 1'b0;
   logic        vld        = 1'b1;
   logic [31:0] wb_dat_out;
   logic [4:0]  slot;
   logic [2:0]  pos;
   logic        wb_ack_out, tx_data_in, rx_data_in, tx_data_out, rx_data_out;
   logic        bit_error_out, int_n_out;
   int          err_count = 0;
   int          checks = 0;
   int          cycles = 0;
   int          ber_cnt = 0;
   // free-running clock
   always #5 sys_clk_in = ~sys_clk_in;
   // error event count and hang guard
   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (bit_error_out === 1'b1)
         ber_cnt++;
      if (cycles == 20000)
      begin
         err_count++;
         final_report();
      end
   end
   ppgc_pattern_gen_check ppgc_pattern_gen_check_i
   (
      .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .wb_adr_in(wb_adr_in),
      .wb_dat_in(wb_dat_in), .wb_sel_in(4'hF), .wb_we_in(wb_we_in),
      .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out),
      .wb_ack_out(wb_ack_out), .tx_valid_in(vld), .tx_data_in(tx_data_in),
      .tx_slot_in(slot), .tx_bit_in(pos), .tx_valid_out(), .tx_data_out(tx_data_out),
      .rx_valid_in(vld), .rx_data_in(rx_data_in), .rx_slot_in(slot), .rx_bit_in(pos),
      .rx_valid_out(), .rx_data_out(rx_data_out), .bit_error_out(bit_error_out),
      .int_n_out(int_n_out)
   );
   ppgc_link_model ppgc_link_model_i
   (
      .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .loop_in(tx_data_out),
      .flip_in(flip), .tx_bit_out(tx_data_in), .rx_bit_out(rx_data_in),
      .slot_out(slot), .pos_out(pos)
   );
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic cycle; entered just after a rising edge
   task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
      wb_adr_in <= {idx, 2'b00};
      wb_dat_in <= d;
      wb_we_in  <= we;
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      do
         @(posedge sys_clk_in);
      while (wb_ack_out !== 1'b1);
      q = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   // stream output must be the input one cycle late
   task automatic pass(input logic use_rx);
      logic p;
      @(posedge sys_clk_in);
      p = use_rx ? rx_data_in : tx_data_in;
      repeat (8)
      begin
         @(posedge sys_clk_in);
         chk(use_rx ? rx_data_out : tx_data_out, p);
         p = use_rx ? rx_data_in : tx_data_in;
      end
   endtask
   task automatic wait_sync;
      logic [31:0] q;
      q = 32'h0;
      for (int n = 0; n < 100 && q[1] !== 1'b1; n++)
         wb(1'b0, 10'h072, 32'h0, q);
      chk(q[1], 32'h1);
   endtask
   task automatic t_reset;
      logic [31:0] q;
      logic [9:0]  idx [5] = '{10'h071, 10'h072, 10'h073, 10'h0C7, 10'h050};
      foreach (idx[i])
      begin
         wb(1'b0, idx[i], 32'h0, q);
         chk(q, 32'h0);
      end
      chk(int_n_out, 32'h1);
      pass(1'b0);
      $display("test reset done");
   endtask
   task automatic t_sync;
      logic [31:0] q;
      for (int s = 0; s < 3; s++)
      begin
         wb(1'b1, 10'h0C7, 32'h0, q);
         // second pass inverts both ends, so lock proves they cancel
         wb(1'b1, 10'h071, 32'(s) | (s == 1 ? 32'hC : 32'h0), q);
         wb(1'b1, 10'h0C7, 32'h1, q);
         wb(1'b1, 10'h073, 32'h3, q);
         wb(1'b1, 10'h072, 32'h8, q);
         wait_sync();
         wb(1'b0, 10'h073, 32'h0, q);
         chk(q[1], 32'h1);
         chk(int_n_out, 32'h0);
         pass(1'b1);
         wb(1'b1, 10'h073, 32'h2, q);
         chk(int_n_out, 32'h1);
      end
      $display("test sync done");
   endtask
   task automatic t_insert;
      logic [31:0] q;
      int          n;
      wb(1'b1, 10'h073, 32'h3, q);
      n = ber_cnt;
      wb(1'b1, 10'h072, 32'h5, q);
      repeat (30) @(posedge sys_clk_in);
      chk(32'(ber_cnt - n), 32'h1);
      wb(1'b0, 10'h073, 32'h0, q);
      chk(q[1:0], 32'h1);
      chk(int_n_out, 32'h0);
      // only this inserted bit has failed since reset
      wb(1'b0, 10'h074, 32'h0, q);
      chk(q, 32'h1);
      wb(1'b1, 10'h073, 32'h1, q);
      chk(int_n_out, 32'h1);
      $display("test insert done");
   endtask
   task automatic t_loss;
      logic [31:0] q;
      int          n;
      wb(1'b1, 10'h0C7, 32'h0, q);
      wb(1'b1, 10'h0C7, 32'h1, q);
      wait_sync();
      wb(1'b1, 10'h073, 32'h3, q);
      n = ber_cnt;
      flip <= 1'b1;
      repeat (100) @(posedge sys_clk_in);
      chk((ber_cnt - n) inside {[11:21]}, 32'h1);
      wb(1'b0, 10'h072, 32'h0, q);
      chk(q[1], 32'h0);
      wb(1'b0, 10'h073, 32'h0, q);
      chk(q[1:0], 32'h3);
      wb(1'b1, 10'h071, 32'h8, q);
      wait_sync();
      flip <= 1'b0;
      $display("test loss done");
   endtask
   // generate on rx, check on tx; slot select and 7-bit lsb
   task automatic t_framed;
      logic [31:0] q;
      logic        p;
      wb(1'b1, 10'h0C7, 32'h0, q);
      wb(1'b1, 10'h0C7, 32'hB, q);
      pass(1'b1);
      pass(1'b0);
      wb(1'b1, 10'h0C8, 32'hFFFF_FFFF, q);
      wb(1'b1, 10'h0C7, 32'hD, q);
      for (int k = 0; k < 16; k++)
      begin
         @(posedge sys_clk_in);
         p = rx_data_in;
         if (pos == 3'h7)
         begin
            @(posedge sys_clk_in);
            chk(rx_data_out, p);
         end
      end
      // no strobe, no replacement even in selected slots
      vld <= 1'b0;
      pass(1'b1);
      vld <= 1'b1;
      $display("test framed done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // reset for three cycles, then the scenarios
   initial
   begin
      repeat (3) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      @(posedge sys_clk_in);
      t_reset();
      t_sync();
      t_insert();
      t_loss();
      t_framed();
      final_report();
   end
endmodule
